// ---- logic/ppt_ping_timer.v ----
// PHY ping timer: transmit parser, ping timer, reply-pending flag, registers
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ppt_consts.vh"
module ppt_ping_timer #(
	parameter NPORT        = 3,
	parameter PORT_W       = 2,
	parameter CLK_PERIOD_NS = `PPT_CLK_PERIOD_NS
) (
	input  wire        CLOCK,
	input  wire        RESET,
	input  wire [3:0]  ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	input  wire        TX_START,
	output wire        TX_BIT_REQ,
	input  wire        TX_TOKEN_VALID,
	input  wire [1:0]  TX_TOKEN,
	output reg         TX_BIT_VALID,
	output reg         TX_BIT,
	output reg         TX_END,
	output reg         TX_PREFIX,
	output reg         TX_ACTIVE,
	output reg  [PORT_W-1:0] RX_PORT,
	input  wire        RX_DATA_START,
	input  wire        RX_PKT_VALID,
	input  wire [63:0] RX_PKT,
	input  wire        RX_DONE,
	output reg         SELF_ID_TX_REQ,
	output wire        SKIP_PARENT_HANDSHAKE,
	input  wire        SELF_ID_TX_DONE,
	output reg         FORCE_ROOT,
	output reg  [5:0]  GAP_COUNT,
	output reg         GAP_RESET_DISABLE
);
	// Stop delay in cycles: least time rounded up, at least one
	localparam STOP_RAW  = (`PPT_STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam STOP_CYC  = (STOP_RAW < 1) ? 1 : STOP_RAW;
	localparam SEP_RAW   = (`PPT_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam SEP_CYC   = (SEP_RAW < 1) ? 1 : SEP_RAW;

	localparam S_IDLE = 4'b0001;
	localparam S_REQ  = 4'b0010;
	localparam S_SEP  = 4'b0100;
	localparam S_DONE = 4'b1000;

	reg  [3:0]  state;
	reg  [3:0]  next_state;
	reg  [63:0] shift;
	reg  [6:0]  bit_count;
	reg  [7:0]  sep_count;
	reg  [7:0]  ping_count;
	reg         timer_run;
	reg  [3:0]  stop_count;
	reg         stop_pending;
	reg         reply_pending;
	reg         in_reply;
	reg  [5:0]  node_id;
	reg         ping_done;
	reg  [7:0]  next_ping_count;
	wire        tx_take;
	wire        tx_pkt_end;
	wire        tx_good;
	wire        tx_cfg;
	wire        rx_cfg;

	// Valid config packet check shared by transmit and receive
	function is_config;
		input [63:0] p;
		begin
			is_config = (p[63:32] == ~p[31:0]) &&
				(p[`PPT_TYPE_HI:`PPT_TYPE_LO] == `PPT_TYPE_CONFIG);
		end
	endfunction

	// Ping: R, T, gap and reserved fields all zero
	function is_ping;
		input [63:0] p;
		begin
			is_ping = is_config(p) && (p[`PPT_FIELDS_HI:`PPT_FIELDS_LO] == 22'h00_0000) &&
				!p[`PPT_R_BIT] && !p[`PPT_T_BIT];
		end
	endfunction

	assign TX_BIT_REQ = (state == S_REQ);
	assign tx_take    = (state == S_REQ) && TX_TOKEN_VALID;
	assign tx_pkt_end = tx_take && (TX_TOKEN == `PPT_TOKEN_END);
	assign tx_good    = (bit_count == `PPT_PKT_BITS);
	assign tx_cfg     = tx_pkt_end && tx_good && is_config(shift);
	assign rx_cfg     = RX_PKT_VALID && is_config(RX_PKT);
	assign SKIP_PARENT_HANDSHAKE = in_reply;

	// Transmit sequencer
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: if (TX_START) next_state = S_REQ;
			S_REQ: begin
				if (tx_take && TX_TOKEN == `PPT_TOKEN_END)
					next_state = S_DONE;
				else if (tx_take && TX_TOKEN == `PPT_TOKEN_PREFIX)
					next_state = S_SEP;
			end
			S_SEP: if (sep_count == 8'h00) next_state = S_DONE;
			S_DONE: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always @(posedge CLOCK) begin
		if (RESET) begin
			state        <= S_IDLE;
			shift        <= 64'h0000_0000_0000_0000;
			bit_count    <= 7'h00;
			sep_count    <= 8'h00;
			TX_BIT_VALID <= 1'b0;
			TX_BIT       <= 1'b0;
			TX_END       <= 1'b0;
			TX_PREFIX    <= 1'b0;
			TX_ACTIVE    <= 1'b0;
			RX_PORT      <= {PORT_W{1'b0}};
		end else begin
			state        <= next_state;
			TX_BIT_VALID <= 1'b0;
			TX_END       <= 1'b0;
			TX_PREFIX    <= 1'b0;
			if (state == S_IDLE && TX_START) begin
				bit_count <= 7'h00;
				TX_ACTIVE <= 1'b1;
				RX_PORT   <= NPORT[PORT_W-1:0];
			end
			if (tx_take) begin
				case (TX_TOKEN)
					`PPT_TOKEN_ZERO, `PPT_TOKEN_ONE: begin
						TX_BIT_VALID <= 1'b1;
						TX_BIT       <= TX_TOKEN[0];
						if (bit_count < `PPT_PKT_BITS) begin
							shift     <= {shift[62:0], TX_TOKEN[0]};
							bit_count <= bit_count + 7'h01;
						end
					end
					`PPT_TOKEN_END: TX_END <= 1'b1;
					default: begin
						TX_PREFIX <= 1'b1;
						sep_count <= SEP_CYC[7:0] - 8'h01;
					end
				endcase
			end
			if (state == S_SEP && sep_count != 8'h00)
				sep_count <= sep_count - 8'h01;
			if (state == S_DONE)
				TX_ACTIVE <= 1'b0;
		end
	end

	// Ping timer
	always @* begin
		next_ping_count = ping_count;
		if (timer_run && ping_count != `PPT_COUNT_MAX)
			next_ping_count = ping_count + 8'h01;
	end

	always @(posedge CLOCK) begin
		if (RESET) begin
			ping_count   <= 8'h00;
			timer_run    <= 1'b0;
			stop_count   <= 4'h0;
			stop_pending <= 1'b0;
			ping_done    <= 1'b0;
		end else begin
			ping_count <= next_ping_count;
			if (tx_pkt_end && tx_good && is_ping(shift)) begin
				ping_count   <= 8'h00;
				timer_run    <= 1'b1;
				stop_pending <= 1'b0;
				ping_done    <= 1'b0;
			end else if (RX_DATA_START && timer_run && !stop_pending) begin
				stop_pending <= 1'b1;
				stop_count   <= STOP_CYC[3:0] - 4'h1;
				if (STOP_CYC == 1) begin
					timer_run    <= 1'b0;
					stop_pending <= 1'b0;
					ping_done    <= 1'b1;
				end
			end else if (stop_pending) begin
				if (stop_count == 4'h0) begin
					timer_run    <= 1'b0;
					stop_pending <= 1'b0;
					ping_done    <= 1'b1;
				end else begin
					stop_count <= stop_count - 4'h1;
				end
			end
		end
	end

	// Config effects, reply-pending and self-id reply
	always @(posedge CLOCK) begin
		if (RESET) begin
			FORCE_ROOT        <= 1'b0;
			GAP_COUNT         <= `PPT_GAP_RESET;
			GAP_RESET_DISABLE <= 1'b0;
			reply_pending     <= 1'b0;
			in_reply          <= 1'b0;
			SELF_ID_TX_REQ    <= 1'b0;
			node_id           <= 6'h00;
		end else begin
			if (tx_cfg) begin
				if (shift[`PPT_R_BIT])
					FORCE_ROOT <= (shift[`PPT_ID_HI:`PPT_ID_LO] == node_id);
				if (shift[`PPT_T_BIT]) begin
					GAP_COUNT         <= shift[`PPT_GAP_HI:`PPT_GAP_LO];
					GAP_RESET_DISABLE <= 1'b1;
				end
			end else if (rx_cfg) begin
				if (RX_PKT[`PPT_R_BIT])
					FORCE_ROOT <= (RX_PKT[`PPT_ID_HI:`PPT_ID_LO] == node_id);
				if (RX_PKT[`PPT_T_BIT]) begin
					GAP_COUNT         <= RX_PKT[`PPT_GAP_HI:`PPT_GAP_LO];
					GAP_RESET_DISABLE <= 1'b1;
				end
			end
			// Consume first so a new ping in the same cycle stays pending
			if (reply_pending && RX_DONE && !SELF_ID_TX_REQ) begin
				reply_pending  <= 1'b0;
				SELF_ID_TX_REQ <= 1'b1;
				in_reply       <= 1'b1;
			end
			if (tx_pkt_end && tx_good && is_ping(shift) &&
				shift[`PPT_ID_HI:`PPT_ID_LO] == node_id)
				reply_pending <= 1'b1;
			if (RX_PKT_VALID && is_ping(RX_PKT) &&
				RX_PKT[`PPT_ID_HI:`PPT_ID_LO] == node_id)
				reply_pending <= 1'b1;
			if (SELF_ID_TX_REQ && SELF_ID_TX_DONE) begin
				SELF_ID_TX_REQ <= 1'b0;
				in_reply       <= 1'b0;
			end
			if (WR && ADDR == `PPT_ADDR_PHYID)
				node_id <= WDATA[5:0];
		end
	end

	// Register read port
	always @(posedge CLOCK) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				`PPT_ADDR_PING_COUNT: RDATA <= ping_count;
				`PPT_ADDR_STATUS: RDATA <= {4'h0, ping_done, reply_pending,
					timer_run, (ping_count == `PPT_COUNT_MAX)};
				`PPT_ADDR_PHYID: RDATA <= {2'b00, node_id};
				`PPT_ADDR_CONFIG: RDATA <= {1'b0, GAP_RESET_DISABLE, GAP_COUNT};
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end
endmodule

// ---- pkg/ppt_consts.vh ----
// Constants for the PHY ping timer block
`ifndef PPT_CONSTS_VH
`define PPT_CONSTS_VH
`define PPT_ADDR_PING_COUNT   4'h0
`define PPT_ADDR_CONFIG       4'h1
`define PPT_ADDR_STATUS       4'h2
`define PPT_ADDR_PHYID        4'h3
`define PPT_PKT_BITS          7'h40
`define PPT_TYPE_CONFIG       2'h0
`define PPT_TYPE_HI           63
`define PPT_TYPE_LO           62
`define PPT_ID_HI             61
`define PPT_ID_LO             56
`define PPT_R_BIT             55
`define PPT_T_BIT             54
`define PPT_GAP_HI            53
`define PPT_GAP_LO            48
`define PPT_FIELDS_HI         53
`define PPT_FIELDS_LO         32
`define PPT_COUNT_MAX         8'hFF
`define PPT_CLK_PERIOD_NS     100
`define PPT_STOP_DELAY_NS     60
`define PPT_SEP_NS            400
`define PPT_GAP_RESET         6'h3F
`define PPT_TOKEN_ZERO        2'h0
`define PPT_TOKEN_ONE         2'h1
`define PPT_TOKEN_END         2'h2
`define PPT_TOKEN_PREFIX      2'h3
`endif

// ---- tb/ppt_chk.sv ----
// Checker of the ping timer ports
`timescale 1ns/100ps
module ppt_chk #(
	parameter NPORT = 3,
	parameter PORT_W = 2
) (
	input logic CLOCK,
	input logic RESET,
	input logic RD,
	input logic [7:0] RDATA,
	input logic TX_BIT_REQ,
	input logic TX_TOKEN_VALID,
	input logic [1:0] TX_TOKEN,
	input logic TX_BIT_VALID,
	input logic TX_BIT,
	input logic TX_END,
	input logic TX_PREFIX,
	input logic TX_ACTIVE,
	input logic [PORT_W-1:0] RX_PORT
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	wire tk = TX_BIT_REQ && TX_TOKEN_VALID;
	bit_out_a: assert property (tk && !TX_TOKEN[1] |=>
		TX_BIT_VALID && {1'b0, TX_BIT} == $past(TX_TOKEN)) else $error("bit lost");
	end_out_a: assert property (tk && TX_TOKEN == 2'h2 |=> TX_END ##1 !TX_ACTIVE)
		else $error("end lost");
	pfx_hold_a: assert property (tk && TX_TOKEN == 2'h3 |=>
		TX_PREFIX ##1 !TX_BIT_REQ [*4]) else $error("prefix hold");
	no_token_a: assert property (!tk |=> !TX_BIT_VALID && !TX_END && !TX_PREFIX)
		else $error("output without token");
	req_act_a: assert property (TX_BIT_REQ |-> TX_ACTIVE && !TX_END) else $error("req");
	start_req_a: assert property ($rose(TX_ACTIVE) |-> TX_BIT_REQ) else $error("start");
	rx_port_a: assert property (TX_ACTIVE |-> RX_PORT == NPORT) else $error("port");
	rd_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("rdata");
	cover property (tk && TX_TOKEN == 2'h3);
	cover property (tk && TX_TOKEN == 2'h2);
	cover property (RD ##1 RDATA == 8'hFF);
endmodule

// ---- tb/ppt_link_model.sv ----
// Link-side model that hands transmit tokens on request
`timescale 1ns/100ps
module ppt_link_model (
	input logic CLOCK,
	input logic RESET,
	input logic TX_BIT_REQ,
	output logic TX_TOKEN_VALID,
	output logic [1:0] TX_TOKEN
);
	logic [1:0] q[$];
	int slow = 0;
	int stall = 0;
	// Token held until taken, then line inverted
	always @(posedge CLOCK) begin
		if (RESET || (TX_TOKEN_VALID && TX_BIT_REQ)) begin
			if (TX_TOKEN_VALID && !RESET)
				void'(q.pop_front());
			TX_TOKEN_VALID <= 1'b0;
			TX_TOKEN <= ~TX_TOKEN;
			stall <= slow;
		end else if (!TX_TOKEN_VALID && TX_BIT_REQ && q.size() > 0) begin
			if (stall > 0)
				stall <= stall - 1;
			else begin
				TX_TOKEN_VALID <= 1'b1;
				TX_TOKEN <= q[0];
			end
		end
	end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the ping timer
`timescale 1ns/100ps
module tb;
	logic CLOCK = 0, RESET = 1, WR = 0, RD = 0, TX_START = 0, RX_DATA_START = 0;
	logic RX_PKT_VALID = 0, RX_DONE = 0, SELF_ID_TX_DONE = 0, TX_ACTIVE, TX_BIT_REQ;
	logic TX_TOKEN_VALID, SELF_ID_TX_REQ, SKIP_PARENT_HANDSHAKE, FORCE_ROOT, GAP_RESET_DISABLE;
	logic [1:0] TX_TOKEN;
	logic [3:0] ADDR = 0;
	logic [5:0] GAP_COUNT;
	logic [7:0] WDATA = 0, RDATA, rv, r1;
	logic [63:0] RX_PKT = 0;
	int mismatches = 0, tests_run = 0, cyc = 0;
	always #50 CLOCK = ~CLOCK;
	ppt_ping_timer #(.NPORT(3), .PORT_W(2)) DUT (.*, .TX_BIT_VALID(), .TX_BIT(), .TX_END(),
		.TX_PREFIX(), .RX_PORT());
	ppt_link_model LINK (.*);
	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end
	task rd(input logic [3:0] a);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1;
		@(posedge CLOCK);
		RD <= 0;
		#1 rv = RDATA;
	endtask
	task strobe(input int s);
		@(posedge CLOCK);
		{SELF_ID_TX_DONE, RX_DONE, RX_DATA_START} <= 3'h1 << s;
		@(posedge CLOCK);
		{SELF_ID_TX_DONE, RX_DONE, RX_DATA_START} <= 3'h0;
		#1;
	endtask
	function automatic logic [63:0] pk(input logic [5:0] id, input logic r, t);
		pk[63:32] = {2'h0, id, r, t, 6'h0A & {6{t}}, 16'h0000};
		pk[31:0] = ~pk[63:32];
	endfunction
	task send(input logic [63:0] p, input int n, input logic [1:0] term);
		for (int i = 63; i > 63 - n; i--)
			LINK.q.push_back({1'b0, p[i]});
		LINK.q.push_back(term);
		@(posedge CLOCK);
		TX_START <= 1;
		@(posedge CLOCK);
		TX_START <= 0;
		repeat (600) begin
			@(posedge CLOCK);
			#1;
			if (TX_ACTIVE === 1'b0)
				break;
		end
	endtask
	task t_config;
		@(posedge CLOCK);
		ADDR <= 4'h3;
		WDATA <= 8'h05;
		WR <= 1;
		@(posedge CLOCK);
		ADDR <= 4'h0;
		WDATA <= 8'h77;
		@(posedge CLOCK);
		WR <= 0;
		send(pk(6'h05, 1, 1), 64, 2'h2);
		check(FORCE_ROOT, 1);
		check(GAP_COUNT, 6'h0A);
		check(GAP_RESET_DISABLE, 1);
		LINK.slow = 2;
		send(pk(6'h09, 1, 0), 64, 2'h2);
		LINK.slow = 0;
		check(FORCE_ROOT, 0);
		rd(4'h0);
		check(rv, 8'h00);
		rd(4'hF);
		check(rv, 8'h00);
		$display("config test done");
	endtask
	task t_ping_self;
		send(pk(6'h05, 0, 0), 64, 2'h2);
		repeat (8) @(posedge CLOCK);
		strobe(0);
		rd(4'h0);
		check(rv >= 8'h0A && rv <= 8'h0D, 1);
		r1 = rv;
		rd(4'h0);
		check(rv, r1);
		strobe(1);
		check(SELF_ID_TX_REQ, 1);
		check(SKIP_PARENT_HANDSHAKE, 1);
		strobe(2);
		check(SELF_ID_TX_REQ, 0);
		$display("self ping test done");
	endtask
	task t_saturate;
		send(pk(6'h09, 0, 0), 64, 2'h2);
		repeat (260) @(posedge CLOCK);
		rd(4'h0);
		check(rv, 8'hFF);
		check(SELF_ID_TX_REQ, 0);
		send(pk(6'h09, 0, 0) ^ 64'h1, 64, 2'h2);
		send(pk(6'h09, 0, 0), 8, 2'h3);
		rd(4'h0);
		check(rv, 8'hFF);
		$display("saturate test done");
	endtask
	task t_rx_ping;
		@(posedge CLOCK);
		RX_PKT <= pk(6'h05, 0, 0);
		RX_PKT_VALID <= 1;
		@(posedge CLOCK);
		RX_PKT_VALID <= 0;
		RX_PKT <= ~RX_PKT;
		strobe(1);
		check(SELF_ID_TX_REQ, 1);
		check(FORCE_ROOT, 0);
		strobe(2);
		$display("receive ping test done");
	endtask
	initial begin
		repeat (20) @(posedge CLOCK);
		RESET <= 0;
		t_config;
		t_ping_self;
		t_saturate;
		t_rx_ping;
		results();
	end
endmodule
bind ppt_ping_timer ppt_chk #(.NPORT(NPORT), .PORT_W(PORT_W)) CHK (.*);
